// [inc/gas_alarm_pkg.sv]
// Shared constants and types for the gas alarm annunciator.
package gas_alarm_pkg;

  // System clock rate in hertz.
  localparam int CLK_HZ = 40_000_000;
  // Base tick period in milliseconds; all slow timing counts these ticks.
  localparam int BASE_TICK_MS = 10;
  localparam int BASE_TICK_CYCLES = CLK_HZ / 1000 * BASE_TICK_MS;

  // Display idle time before returning to the home page, in seconds.
  localparam int IDLE_TIMEOUT_S = 60;
  localparam int MINUTE_TICKS = IDLE_TIMEOUT_S * 1000 / BASE_TICK_MS;
  // One second in ticks, used for blink phase and backlight timeout.
  localparam int SECOND_MS = 1000;
  localparam int SECOND_TICKS = SECOND_MS / BASE_TICK_MS;
  // Decline key hold time that switches the backlight on.
  localparam int BL_HOLD_MS = 1000;
  localparam int BL_HOLD_TICKS = BL_HOLD_MS / BASE_TICK_MS;
  // Length of one single beep or flash (self-test, battery chirp).
  localparam int BEEP_MS = 100;
  localparam int BEEP_TICKS = BEEP_MS / BASE_TICK_MS;

  // Blink periods in ticks for one, two and three flashes per second.
  localparam int PERIOD_1HZ = SECOND_TICKS / 1;
  localparam int PERIOD_2HZ = SECOND_TICKS / 2;
  localparam int PERIOD_3HZ = SECOND_TICKS / 3;

  // Page counts per user mode.
  localparam int TEXT_PAGES = 4;
  localparam int FULL_PAGES = 12;

  // Alarm class positions, listed from highest message priority down.
  localparam int CLS_PUMP = 0;
  localparam int CLS_LAMP = 1;
  localparam int CLS_SENSOR_OFF = 2;
  localparam int CLS_DRIFT = 3;
  localparam int CLS_OVER_RANGE = 4;
  localparam int CLS_HIGH = 5;
  localparam int CLS_LOW = 6;
  localparam int CLS_AVG = 7;
  localparam int CLS_BATTERY = 8;
  localparam int CLS_MEMORY = 9;
  localparam int N_CLASSES = 10;

  // Message shown on the display; the code is class position plus one.
  typedef enum logic [3:0] {
    MSG_NONE = 4'h0,
    MSG_PUMP = 4'h1,
    MSG_LAMP = 4'h2,
    MSG_SENSOR_OFF = 4'h3,
    MSG_NEGATIVE_DRIFT_TEXT = 4'h4,
    MSG_OVER_RANGE_TEXT = 4'h5,
    MSG_HIGH_LIMIT = 4'h6,
    MSG_LOW_LIMIT = 4'h7,
    MSG_AVERAGE_LIMIT = 4'h8,
    MSG_BATTERY = 4'h9,
    MSG_MEMORY_FULL = 4'hA
  } msg_e;

endpackage

// [testbench/gas_alarm_annunciator_tb.sv]
// Self-checking bench for the gas alarm annunciator.
`timescale 1ns/100ps
`default_nettype none
module gas_alarm_annunciator_tb;
  // Short ticks of TK cycles keep the run brief; step counts below are in cycles.
  localparam int NS = 5;
  localparam int TK = 4;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic mode_key, confirm_key, decline_key, pump_stall;
  logic [NS-1:0] high_exceed = '0, low_exceed = '0, stel_exceed = '0;
  logic [NS-1:0] twa_exceed = '0, negative_drift = '0, over_range = '0;
  logic battery_low = 1'b0, lamp_fail = 1'b0, sensor_off = 1'b0;
  logic memory_full = 1'b0, pc_standby = 1'b0, calibration_mode = 1'b0;
  logic latch_mode = 1'b0, text_mode = 1'b0;
  logic backlight_auto = 1'b0, ambient_dark = 1'b0;
  logic [7:0] backlight_timeout_s = 8'h00;
  logic buzzer, led, backlight, pump_on, power_down, measure_hold;
  logic [3:0] page, message;
  logic [2:0] message_sensor;
  int bad_count = 0;
  int compares = 0;
  // Expected message per class in set_cls order.
  logic [3:0] codes [8] = '{4'h6, 4'h7, 4'h8, 4'h8, 4'h4, 4'h5, 4'h2, 4'h3};

  always #12.5 clk = ~clk;

  gas_alarm_annunciator #(.N_SENSORS(NS), .BASE_TICK_CYCLES(TK),
    .MINUTE_TICKS(20)) DUT (.clk, .resetn, .mode_key, .confirm_key,
    .decline_key, .high_exceed, .low_exceed, .stel_exceed, .twa_exceed,
    .negative_drift, .over_range, .battery_low, .lamp_fail, .sensor_off,
    .pump_stall, .memory_full, .pc_standby, .calibration_mode, .latch_mode,
    .text_mode, .backlight_auto, .ambient_dark, .backlight_timeout_s,
    .buzzer, .led, .backlight, .pump_on, .power_down, .measure_hold, .page,
    .message, .message_sensor);

  user_panel_model u_panel (.clk, .pump_on, .mode_key, .confirm_key,
    .decline_key, .pump_stall);

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Inputs move only at falling edges, away from the sampling edge.
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Raises or drops one alarm class; s picks the sensor.
  task automatic set_cls(input int k, input logic v, input int s);
    case (k)
      0: high_exceed[s] = v;
      1: low_exceed[s] = v;
      2: stel_exceed[s] = v;
      3: twa_exceed[s] = v;
      4: negative_drift[s] = v;
      5: over_range[s] = v;
      6: lamp_fail = v;
      default: sensor_off = v;
    endcase
  endtask

  // Waits, bounded, for the LED to reach a level.
  task automatic wait_led(input logic v);
    int n;
    n = 0;
    while (led !== v && n < 300)
    begin
      step(1);
      n++;
    end
  endtask

  // Measures a whole LED pulse; the first one may be cut by tick phase.
  task automatic led_len(input int exp_c);
    int n;
    step(3);
    wait_led(1'b0);
    wait_led(1'b1);
    n = 0;
    while (led === 1'b1 && n < 300)
    begin
      step(1);
      n++;
    end
    chk("led on cycles", n, exp_c);
  endtask

  task automatic end_of_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // The tests take about 4000 cycles; five times that means a hang.
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_of_test();
  end

  initial
  begin
    int s;
    int n;
    void'($urandom(32'hd1a7));
    repeat (8) @(posedge clk);
    step(1);
    resetn = 1'b1;
    chk("pump_on", pump_on, 1);
    text_mode = 1'b1;
    n = 1 + $urandom % 9;
    repeat (n) u_panel.press(0, 4);
    chk("page text", page, n % 4);
    // The ring in full mode starts from the page text mode left.
    s = n % 4;
    text_mode = 1'b0;
    n = 13 + $urandom % 10;
    repeat (n) u_panel.press(0, 4);
    step(60);
    chk("page full", page, (s + n) % 12);
    step(40);
    chk("page idle", page, 0);
    // The gas classes, lamp and sensor-off each alone, then released in auto mode.
    for (int k = 0; k < 8; k++)
    begin
      s = $urandom % NS;
      set_cls(k, 1'b1, s);
      step(3);
      chk("message", message, codes[k]);
      if (k < 6)
        chk("sensor", message_sensor, s);
      chk("led", led, 1);
      chk("buzzer", buzzer, 1);
      set_cls(k, 1'b0, s);
      step(3);
      chk("led free", led, 0);
      chk("msg free", message, 0);
    end
    set_cls(0, 1'b1, 0);
    led_len(16 * TK);
    set_cls(0, 1'b0, 0);
    low_exceed[1] = 1'b1;
    led_len(25 * TK);
    stel_exceed[3] = 1'b1;
    step(2);
    chk("msg mix", message, 7);
    chk("sensor mix", message_sensor, 1);
    led_len(25 * TK);
    low_exceed = '0;
    led_len(50 * TK);
    stel_exceed = '0;
    // Latching keeps the alarm until confirm with the cause gone.
    latch_mode = 1'b1;
    high_exceed[4] = 1'b1;
    step(3);
    high_exceed = '0;
    led_len(16 * TK);
    chk("msg latch", message, 6);
    u_panel.press(1, 4);
    step(60);
    chk("msg unlatch", message, 0);
    latch_mode = 1'b0;
    // Both silencing modes hide a live alarm.
    for (int m = 0; m < 2; m++)
    begin
      pc_standby = (m == 0);
      calibration_mode = (m == 1);
      high_exceed[0] = 1'b1;
      step(40);
      chk("led quiet", led, 0);
      chk("buzzer quiet", buzzer, 0);
      chk("hold", measure_hold, 1);
      high_exceed = '0;
      pc_standby = 1'b0;
      calibration_mode = 1'b0;
      step(3);
      chk("hold off", measure_hold, 0);
    end
    memory_full = 1'b1;
    step(3);
    chk("led mem", led, 1);
    chk("buzzer mem on", buzzer, 0);
    led_len(50 * TK);
    chk("buzzer mem", buzzer, 0);
    memory_full = 1'b0;
    step(60);
    u_panel.press(1, 4);
    chk("test buzzer", buzzer, 1);
    chk("test led", led, 1);
    chk("test light", backlight, 1);
    step(60);
    u_panel.jam = 1'b1;
    step(3);
    chk("pump stop", pump_on, 0);
    chk("msg pump", message, 1);
    u_panel.jam = 1'b0;
    step(20);
    chk("pump stays off", pump_on, 0);
    u_panel.press(1, 4);
    chk("pump restart", pump_on, 1);
    step(60);
    // Manual light: hold one second, press again, then timeout.
    u_panel.press(2, 100 * TK + 12);
    chk("light on", backlight, 1);
    u_panel.press(2, 4);
    chk("light off", backlight, 0);
    backlight_timeout_s = 8'h01;
    u_panel.press(2, 100 * TK + 12);
    step(300);
    chk("light held", backlight, 1);
    step(120);
    chk("light timeout", backlight, 0);
    backlight_auto = 1'b1;
    ambient_dark = 1'b1;
    step(3);
    chk("auto on", backlight, 1);
    ambient_dark = 1'b0;
    step(3);
    chk("auto off", backlight, 0);
    // Battery last, since power-down only clears by reset.
    battery_low = 1'b1;
    // The first chirp waits for the next tick, up to four cycles.
    step(6);
    chk("power down", power_down, 1);
    chk("msg battery", message, 9);
    chk("chirp", buzzer, 1);
    step(50);
    chk("chirp end", buzzer, 0);
    chk("led battery", led, 1);
    step(40);
    chk("chirp again", buzzer, 1);
    battery_low = 1'b0;
    step(3);
    chk("power sticky", power_down, 1);
    end_of_test();
  end
endmodule
`default_nettype wire

// [testbench/user_panel_model.sv]
// Keypad and sampling pump model that faces the annunciator.
`timescale 1ns/100ps
`default_nettype none
module user_panel_model
(
  input wire logic clk,
  input wire logic pump_on,
  output logic mode_key,
  output logic confirm_key,
  output logic decline_key,
  output logic pump_stall
);
  // Key levels: bit 0 mode, bit 1 confirm, bit 2 decline.
  logic [2:0] keys = 3'h0;
  // Obstruction in the inlet, placed and cleared by the bench.
  logic jam = 1'b0;

  assign mode_key = keys[0];
  assign confirm_key = keys[1];
  assign decline_key = keys[2];
  // A jammed pump only reports a stall while it is driven.
  assign pump_stall = jam & pump_on;

  // Holds one key for some cycles, then keeps it low long enough that
  // the synchroniser sees a fresh edge on the next press.
  task automatic press(input int k, input int hold);
    @(negedge clk);
    keys[k] = 1'b1;
    repeat (hold) @(negedge clk);
    keys[k] = 1'b0;
    repeat (4) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// [verilog/gas_alarm_annunciator.sv]
// Alarm, display page, backlight and pump sequencer for a gas monitor.
`timescale 1ns/100ps
`default_nettype none

module gas_alarm_annunciator
#(
  parameter int N_SENSORS = 5,
  parameter int BASE_TICK_CYCLES = gas_alarm_pkg::BASE_TICK_CYCLES,
  parameter int MINUTE_TICKS = gas_alarm_pkg::MINUTE_TICKS
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic mode_key,
  input wire logic confirm_key,
  input wire logic decline_key,
  input wire logic [N_SENSORS-1:0] high_exceed,
  input wire logic [N_SENSORS-1:0] low_exceed,
  input wire logic [N_SENSORS-1:0] stel_exceed,
  input wire logic [N_SENSORS-1:0] twa_exceed,
  input wire logic [N_SENSORS-1:0] negative_drift,
  input wire logic [N_SENSORS-1:0] over_range,
  input wire logic battery_low,
  input wire logic lamp_fail,
  input wire logic sensor_off,
  input wire logic pump_stall,
  input wire logic memory_full,
  input wire logic pc_standby,
  input wire logic calibration_mode,
  input wire logic latch_mode,
  input wire logic text_mode,
  input wire logic backlight_auto,
  input wire logic ambient_dark,
  input wire logic [7:0] backlight_timeout_s,
  output logic buzzer,
  output logic led,
  output logic backlight,
  output logic pump_on,
  output logic power_down,
  output logic measure_hold,
  output logic [3:0] page,
  output logic [3:0] message,
  output logic [2:0] message_sensor
);

  // Typed copies of the timing counts at the widths they meet.
  localparam logic [15:0] MIN_LAST = 16'(MINUTE_TICKS - 1);
  localparam logic [6:0] SEC_LAST = 7'(gas_alarm_pkg::SECOND_TICKS - 1);
  localparam logic [6:0] HOLD_T = 7'(gas_alarm_pkg::BL_HOLD_TICKS);
  localparam logic [6:0] BEEP_T = 7'(gas_alarm_pkg::BEEP_TICKS);
  localparam logic [6:0] P1 = 7'(gas_alarm_pkg::PERIOD_1HZ);
  localparam logic [6:0] P2 = 7'(gas_alarm_pkg::PERIOD_2HZ);
  localparam logic [6:0] P3 = 7'(gas_alarm_pkg::PERIOD_3HZ);
  localparam logic [3:0] TEXT_N = 4'(gas_alarm_pkg::TEXT_PAGES);
  localparam logic [3:0] FULL_N = 4'(gas_alarm_pkg::FULL_PAGES);
  localparam int NC = gas_alarm_pkg::N_CLASSES;

  // Whole state of the block.
  typedef struct packed {
    logic mode_s1;             // Key synchroniser first stages.
    logic conf_s1;
    logic dec_s1;
    logic mode_s2;             // Key synchroniser second stages.
    logic conf_s2;
    logic dec_s2;
    logic mode_prev;           // Previous synchronised key levels.
    logic conf_prev;
    logic dec_prev;
    logic [3:0] page;          // Current display page, 0 is home.
    logic [15:0] idle_cnt;     // Ticks since the last key press.
    logic [NC-1:0] latched;    // Conditions held in latching mode.
    logic [1:0] rate;          // Flashes per second now shown.
    logic [6:0] phase;         // Position inside one blink period.
    logic [15:0] min_cnt;      // Minute counter for battery chirp.
    logic [6:0] chirp_cnt;     // Remaining ticks of battery chirp.
    logic [6:0] test_cnt;      // Remaining ticks of self-test.
    logic bl_on;               // Manual backlight state.
    logic [6:0] bl_hold;       // Ticks the decline key has been held.
    logic [6:0] bl_sec;        // Tick count inside one second.
    logic [7:0] bl_left;       // Seconds left before backlight off.
    logic stalled;             // Pump stopped by a stall.
    logic pump_on;
    logic power_down;
    logic buzzer;
    logic led;
    logic backlight;
    logic measure_hold;
    logic [3:0] message;
    logic [2:0] message_sensor;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  // Slow enable pulse that paces every timer in the block.
  logic tick;

  tick_divider #(.DIV(BASE_TICK_CYCLES)) u_tick
  (
    .clk(clk),
    .resetn(resetn),
    .tick(tick)
  );

  // Index of the lowest sensor whose flag is set.
  function automatic logic [2:0] first_idx(input logic [N_SENSORS-1:0] v);
    logic [2:0] r;
    r = '0;
    for (int i = N_SENSORS - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // Key press edges, taken only from the second synchroniser stage.
  logic mode_press;
  logic conf_press;
  logic dec_press;
  logic suppress;
  logic [NC-1:0] cond;
  logic [NC-1:0] active;

  assign mode_press = st_ff.mode_s2 & ~st_ff.mode_prev;
  assign conf_press = st_ff.conf_s2 & ~st_ff.conf_prev;
  assign dec_press = st_ff.dec_s2 & ~st_ff.dec_prev;
  // Alarms and measurement are held off in standby or calibration.
  assign suppress = pc_standby | calibration_mode;

  // Raw alarm conditions, one bit per class.
  always_comb
  begin
    cond = '0;
    cond[gas_alarm_pkg::CLS_PUMP] = st_ff.stalled;
    cond[gas_alarm_pkg::CLS_LAMP] = lamp_fail;
    cond[gas_alarm_pkg::CLS_SENSOR_OFF] = sensor_off;
    cond[gas_alarm_pkg::CLS_DRIFT] = |negative_drift;
    cond[gas_alarm_pkg::CLS_OVER_RANGE] = |over_range;
    cond[gas_alarm_pkg::CLS_HIGH] = |high_exceed;
    cond[gas_alarm_pkg::CLS_LOW] = |low_exceed;
    cond[gas_alarm_pkg::CLS_AVG] = |(stel_exceed | twa_exceed);
    cond[gas_alarm_pkg::CLS_BATTERY] = battery_low;
    cond[gas_alarm_pkg::CLS_MEMORY] = memory_full;
  end

  // Live conditions plus held ones in latching mode; none when silenced.
  assign active = suppress ? '0 :
                  (cond | (latch_mode ? st_ff.latched : '0));

  // Next-state logic for the whole block.
  always_comb
  begin
    logic [6:0] period;
    logic wave;
    logic [3:0] pages;
    logic [NC-1:0] clr;
    nxt_st = st_ff;
    period = P1;
    wave = 1'b0;
    pages = text_mode ? TEXT_N : FULL_N;
    clr = '0;

    // Two-stage key synchronisers and edge history.
    nxt_st.mode_s1 = mode_key;
    nxt_st.conf_s1 = confirm_key;
    nxt_st.dec_s1 = decline_key;
    nxt_st.mode_s2 = st_ff.mode_s1;
    nxt_st.conf_s2 = st_ff.conf_s1;
    nxt_st.dec_s2 = st_ff.dec_s1;
    nxt_st.mode_prev = st_ff.mode_s2;
    nxt_st.conf_prev = st_ff.conf_s2;
    nxt_st.dec_prev = st_ff.dec_s2;

    // Page stepping; any key restarts the idle minute.
    if (mode_press | conf_press | dec_press)
    begin
      nxt_st.idle_cnt = '0;
    end
    else if (tick)
    begin
      if (st_ff.idle_cnt >= MIN_LAST)
      begin
        nxt_st.idle_cnt = '0;
        nxt_st.page = '0;
      end
      else
      begin
        nxt_st.idle_cnt = st_ff.idle_cnt + 16'h0001;
      end
    end
    if (mode_press)
    begin
      // Ring order: the last page wraps back to the home page.
      if (st_ff.page >= pages - 4'h1)
      begin
        nxt_st.page = '0;
      end
      else
      begin
        nxt_st.page = st_ff.page + 4'h1;
      end
    end
    else if (st_ff.page >= pages)
    begin
      // A mode change left the page outside the ring.
      nxt_st.page = '0;
    end

    // Latched conditions clear on a confirm press once gone; a new
    // occurrence in the same cycle keeps its bit set.
    if (conf_press)
    begin
      clr = ~cond;
    end
    if (latch_mode)
    begin
      nxt_st.latched = (st_ff.latched & ~clr) |
                       (suppress ? '0 : cond);
    end
    else
    begin
      nxt_st.latched = '0;
    end

    // Pump stall stops the pump until a confirm press; stall wins.
    if (pump_stall)
    begin
      nxt_st.stalled = 1'b1;
    end
    else if (conf_press)
    begin
      nxt_st.stalled = 1'b0;
    end
    nxt_st.pump_on = ~nxt_st.stalled;

    // Fastest rate among the active classes sets the blink rate.
    if (|active[gas_alarm_pkg::CLS_HIGH:0])
    begin
      nxt_st.rate = 2'd3;
    end
    else if (active[gas_alarm_pkg::CLS_LOW])
    begin
      nxt_st.rate = 2'd2;
    end
    else if (|active[NC-1:gas_alarm_pkg::CLS_AVG])
    begin
      nxt_st.rate = 2'd1;
    end
    else
    begin
      nxt_st.rate = 2'd0;
    end

    // Blink phase restarts whenever the rate changes.
    case (st_ff.rate)
      2'd3: period = P3;
      2'd2: period = P2;
      default: period = P1;
    endcase
    wave = (st_ff.rate != 2'd0) && (st_ff.phase < (period >> 1));
    if (nxt_st.rate != st_ff.rate)
    begin
      nxt_st.phase = '0;
    end
    else if (tick)
    begin
      nxt_st.phase = (st_ff.phase >= period - 7'h01) ? '0 :
                     st_ff.phase + 7'h01;
    end

    // Battery chirp once a minute, the first one at once.
    if (!active[gas_alarm_pkg::CLS_BATTERY])
    begin
      nxt_st.min_cnt = MIN_LAST;
    end
    else if (tick)
    begin
      if (st_ff.min_cnt >= MIN_LAST)
      begin
        nxt_st.min_cnt = '0;
        nxt_st.chirp_cnt = BEEP_T;
      end
      else
      begin
        nxt_st.min_cnt = st_ff.min_cnt + 16'h0001;
      end
    end
    if (tick && st_ff.chirp_cnt != '0)
    begin
      nxt_st.chirp_cnt = st_ff.chirp_cnt - 7'h01;
    end

    // Self-test runs only from a quiet, unsilenced state.
    if (conf_press && active == '0 && !suppress)
    begin
      nxt_st.test_cnt = BEEP_T;
    end
    else if (tick && st_ff.test_cnt != '0)
    begin
      nxt_st.test_cnt = st_ff.test_cnt - 7'h01;
    end

    // Manual backlight: timeout first, then press off, then hold on.
    if (!st_ff.dec_s2)
    begin
      nxt_st.bl_hold = '0;
    end
    else if (tick && st_ff.bl_hold != HOLD_T)
    begin
      nxt_st.bl_hold = st_ff.bl_hold + 7'h01;
    end
    if (backlight_auto)
    begin
      nxt_st.bl_on = 1'b0;
    end
    else
    begin
      if (st_ff.bl_on && tick)
      begin
        if (st_ff.bl_sec >= SEC_LAST)
        begin
          nxt_st.bl_sec = '0;
          // A zero timeout keeps the light on until the next press.
          if (st_ff.bl_left == 8'h01)
          begin
            nxt_st.bl_on = 1'b0;
          end
          if (st_ff.bl_left != 8'h00)
          begin
            nxt_st.bl_left = st_ff.bl_left - 8'h01;
          end
        end
        else
        begin
          nxt_st.bl_sec = st_ff.bl_sec + 7'h01;
        end
      end
      if (dec_press && st_ff.bl_on)
      begin
        nxt_st.bl_on = 1'b0;
      end
      else if (tick && st_ff.bl_hold == HOLD_T - 7'h01 && !st_ff.bl_on)
      begin
        nxt_st.bl_on = 1'b1;
        nxt_st.bl_left = backlight_timeout_s;
        nxt_st.bl_sec = '0;
      end
    end

    // Outputs; the buzzer skips battery and memory blink.
    nxt_st.buzzer = !suppress &&
                    ((wave && |active[gas_alarm_pkg::CLS_AVG:0]) ||
                     st_ff.chirp_cnt != '0 ||
                     st_ff.test_cnt != '0);
    nxt_st.led = !suppress && (wave || st_ff.test_cnt != '0);
    nxt_st.backlight = (backlight_auto ? ambient_dark : st_ff.bl_on) ||
                       st_ff.test_cnt != '0;
    nxt_st.power_down = st_ff.power_down | battery_low;
    nxt_st.measure_hold = suppress;

    // Message of the highest-priority active class.
    nxt_st.message = gas_alarm_pkg::MSG_NONE;
    for (int c = NC - 1; c >= 0; c--)
    begin
      if (active[c])
      begin
        nxt_st.message = 4'(c + 1);
      end
    end
    case (nxt_st.message)
      gas_alarm_pkg::MSG_NEGATIVE_DRIFT_TEXT:
        nxt_st.message_sensor = first_idx(negative_drift);
      gas_alarm_pkg::MSG_OVER_RANGE_TEXT:
        nxt_st.message_sensor = first_idx(over_range);
      gas_alarm_pkg::MSG_HIGH_LIMIT:
        nxt_st.message_sensor = first_idx(high_exceed);
      gas_alarm_pkg::MSG_LOW_LIMIT:
        nxt_st.message_sensor = first_idx(low_exceed);
      gas_alarm_pkg::MSG_AVERAGE_LIMIT:
        nxt_st.message_sensor = first_idx(stel_exceed | twa_exceed);
      default:
        nxt_st.message_sensor = st_ff.message_sensor;
    endcase
  end

  // State register; the pump runs from reset onward.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_ff <= '0;
      st_ff.pump_on <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign buzzer = st_ff.buzzer;
  assign led = st_ff.led;
  assign backlight = st_ff.backlight;
  assign pump_on = st_ff.pump_on;
  assign power_down = st_ff.power_down;
  assign measure_hold = st_ff.measure_hold;
  assign page = st_ff.page;
  assign message = st_ff.message;
  assign message_sensor = st_ff.message_sensor;

  // Checks on the behaviour above.
  idle_home_a: assert property (@(posedge clk) disable iff (!resetn)
    tick && st_ff.idle_cnt >= MIN_LAST && !(mode_press | conf_press |
    dec_press) |=> page == 4'h0)
    else $error("idle minute did not return home");
  text_wrap_a: assert property (@(posedge clk) disable iff (!resetn)
    mode_press && text_mode && page == 4'h3 |=> page == 4'h0)
    else $error("text page ring did not wrap");
  full_wrap_a: assert property (@(posedge clk) disable iff (!resetn)
    mode_press && !text_mode && page == 4'hB |=> page == 4'h0)
    else $error("full page ring did not wrap");
  power_off_a: assert property (@(posedge clk) disable iff (!resetn)
    battery_low |=> power_down [*3])
    else $error("low battery did not power down");
  silent_a: assert property (@(posedge clk) disable iff (!resetn)
    suppress |=> !buzzer && !led && measure_hold)
    else $error("alarm output while silenced");
  latch_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    latch_mode && !suppress && $fell(|high_exceed) && !conf_press
    |-> ##1 st_ff.rate == 2'd3)
    else $error("latched alarm released");
  high_rate_a: assert property (@(posedge clk) disable iff (!resetn)
    |high_exceed && !suppress |=> st_ff.rate == 2'd3 &&
    message <= gas_alarm_pkg::MSG_HIGH_LIMIT)
    else $error("high limit rate wrong");
  low_rate_a: assert property (@(posedge clk) disable iff (!resetn)
    !latch_mode && !suppress && cond == (NC'(1) << gas_alarm_pkg::CLS_LOW)
    |=> st_ff.rate == 2'd2)
    else $error("low limit rate wrong");
  mem_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
    !latch_mode && cond == (NC'(1) << gas_alarm_pkg::CLS_MEMORY) &&
    st_ff.chirp_cnt == '0 && st_ff.test_cnt == '0 |=> !buzzer)
    else $error("memory full sounded buzzer");
  stall_stop_a: assert property (@(posedge clk) disable iff (!resetn)
    pump_stall |=> !pump_on ##1 (!pump_on || $past(conf_press)))
    else $error("pump kept running on stall");

endmodule
`default_nettype wire

// [verilog/tick_divider.sv]
// Clock divider that yields a one-cycle enable pulse every DIV cycles.
`timescale 1ns/100ps
`default_nettype none

module tick_divider
#(
  parameter int DIV = 400000
)
(
  input wire logic clk,
  input wire logic resetn,
  output logic tick
);

  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  // Free-running count; the pulse marks its wrap.
  logic [W-1:0] cnt_ff;
  logic tick_ff;

  // Count and raise the pulse for exactly one cycle per period.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= (cnt_ff == LAST) ? '0 : cnt_ff + 1'b1;
      tick_ff <= (cnt_ff == LAST);
    end
  end

  assign tick = tick_ff;

endmodule
`default_nettype wire
